// ---- hdl/mne_pkg.sv ----
package mne_pkg;

  // instruction fields
  localparam int         OPC_MUL_MSB   = 15;
  localparam int         OPC_MUL_LSB   = 8;
  localparam logic [7:0] OPC_MUL       = 8'h34;
  localparam int         OPC_NEG_MSB   = 15;
  localparam int         OPC_NEG_LSB   = 9;
  localparam logic [6:0] OPC_NEG       = 7'h16;
  localparam int         STORE_SEL_BIT = 8;
  localparam int         FILE_ADDR_MSB = 7;
  localparam int         FILE_ADDR_LSB = 0;

  // reset values
  localparam logic [7:0]  WORKING_REGISTER_RST   = 8'h00;
  localparam logic [7:0]  PROD_RST   = 8'h00;
  localparam logic [15:0] RESULT_RST = 16'h0000;
  localparam logic [7:0]  ADDR_RST   = 8'h00;

  // negate corner values
  localparam logic [7:0] NEG_WRAP_VAL = 8'h80;
  localparam logic [7:0] ONE_BYTE     = 8'h01;

  typedef enum logic [1:0] {
    MNE_Q1 = 2'b00,
    MNE_Q2 = 2'b01,
    MNE_Q3 = 2'b11,
    MNE_Q4 = 2'b10
  } mne_phase_t;

  typedef enum logic [1:0] {
    MNE_OP_NONE = 2'b00,
    MNE_OP_MUL  = 2'b01,
    MNE_OP_NEG  = 2'b10
  } mne_op_t;

  typedef struct packed {
    logic signed_wrap_flag;
    logic carry;
    logic half_carry_flag;
    logic zero;
  } mne_flags_t;

  localparam mne_flags_t FLAGS_RST = '{default: 1'b0};

  typedef struct packed {
    logic [7:0] addr;
    logic       re;
    logic       we;
    logic [7:0] wdata;
  } mne_mem_req_t;

  typedef struct packed {
    mne_phase_t   phase;
    mne_op_t      op;
    logic         store_sel;
    logic [15:0]  result;
    logic [7:0]   working_register;
    logic [7:0]   product_high;
    logic [7:0]   product_low;
    mne_flags_t   flags;
    mne_mem_req_t mem;
  } mne_state_t;

endpackage : mne_pkg

// ---- hdl/mne_exec.sv ----
`timescale 1ns/1ps
module mne_exec
  import mne_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  // instruction from decoder
  input  wire logic [15:0] instr_word,
  input  wire logic        instr_valid,
  // working register load from rest of core
  input  wire logic        working_register_load,
  input  wire logic [7:0]  working_register_load_data,
  // data memory
  output logic      [7:0]  mem_addr,
  output logic             mem_re,
  input  wire logic [7:0]  mem_rdata,
  output logic             mem_we,
  output logic      [7:0]  mem_wdata,
  // architectural state
  output logic      [7:0]  working_register,
  output logic      [7:0]  product_high,
  output logic      [7:0]  product_low,
  output mne_flags_t       flags,
  output mne_phase_t       q_phase
);

  mne_state_t s_r;
  mne_state_t s_nxt;
  logic [7:0] neg_val;

  assign neg_val = 8'(~s_r.working_register + ONE_BYTE);

  always_comb begin
    s_nxt        = s_r;
    s_nxt.mem.re = 1'b0;
    s_nxt.mem.we = 1'b0;
    case (s_r.phase)
      MNE_Q1: begin
        s_nxt.phase = MNE_Q2;
        s_nxt.op    = MNE_OP_NONE;
        if (instr_valid) begin
          s_nxt.mem.addr  = instr_word[FILE_ADDR_MSB:FILE_ADDR_LSB];
          s_nxt.store_sel = instr_word[STORE_SEL_BIT];
          if (instr_word[OPC_MUL_MSB:OPC_MUL_LSB] == OPC_MUL) begin
            s_nxt.op     = MNE_OP_MUL;
            s_nxt.mem.re = 1'b1;
          end else if (instr_word[OPC_NEG_MSB:OPC_NEG_LSB] == OPC_NEG) begin
            s_nxt.op     = MNE_OP_NEG;
            s_nxt.mem.re = 1'b1;
          end
        end
      end
      MNE_Q2: begin
        s_nxt.phase = MNE_Q3;
      end
      MNE_Q3: begin
        s_nxt.phase = MNE_Q4;
        // read data is valid in Q3; results land at the Q3/Q4 edge
        if (s_r.op == MNE_OP_MUL) begin
          s_nxt.result       = 16'(s_r.working_register) * 16'(mem_rdata);
          s_nxt.product_high = s_nxt.result[15:8];
          s_nxt.product_low  = s_nxt.result[7:0];
        end else if (s_r.op == MNE_OP_NEG) begin
          s_nxt.result    = {8'h00, neg_val};
          s_nxt.mem.we    = 1'b1;
          s_nxt.mem.wdata = neg_val;
          if (!s_r.store_sel) begin
            s_nxt.working_register = neg_val;
          end
          // flags as for 0 minus working register, carry meaning no borrow
          s_nxt.flags.zero             = (neg_val == 8'h00);
          s_nxt.flags.carry            = (s_r.working_register == 8'h00);
          s_nxt.flags.half_carry_flag  = (s_r.working_register[3:0] == 4'h0);
          s_nxt.flags.signed_wrap_flag = (s_r.working_register == NEG_WRAP_VAL);
        end
      end
      MNE_Q4: begin
        s_nxt.phase = MNE_Q1;
      end
      default: begin
        s_nxt.phase = MNE_Q1;
      end
    endcase
    // outside loads are refused while one of our instructions is in flight
    if (working_register_load && s_r.op == MNE_OP_NONE && s_r.phase != MNE_Q1) begin
      s_nxt.working_register = working_register_load_data;
    end else if (working_register_load && s_r.phase == MNE_Q1 && s_nxt.op == MNE_OP_NONE) begin
      s_nxt.working_register = working_register_load_data;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_r.phase            <= MNE_Q1;
      s_r.op               <= MNE_OP_NONE;
      s_r.store_sel        <= 1'b0;
      s_r.result           <= RESULT_RST;
      s_r.working_register <= WORKING_REGISTER_RST;
      s_r.product_high     <= PROD_RST;
      s_r.product_low      <= PROD_RST;
      s_r.flags            <= FLAGS_RST;
      s_r.mem.addr         <= ADDR_RST;
      s_r.mem.re           <= 1'b0;
      s_r.mem.we           <= 1'b0;
      s_r.mem.wdata        <= WORKING_REGISTER_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign mem_addr         = s_r.mem.addr;
  assign mem_re           = s_r.mem.re;
  assign mem_we           = s_r.mem.we;
  assign mem_wdata        = s_r.mem.wdata;
  assign working_register = s_r.working_register;
  assign product_high     = s_r.product_high;
  assign product_low      = s_r.product_low;
  assign flags            = s_r.flags;
  assign q_phase          = s_r.phase;

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  a_mul_product_value: assert property (
    (s_r.phase == MNE_Q3 && s_r.op == MNE_OP_MUL) |=>
      ({product_high, product_low} == 16'($past(working_register)) * 16'($past(mem_rdata))))
    else $error("product differs from operands");

  a_mul_byte_split: assert property (
    (s_r.phase == MNE_Q3 && s_r.op == MNE_OP_MUL) |=>
      (product_high == 8'((16'($past(working_register)) * 16'($past(mem_rdata))) >> 8)
       && product_low == 8'($past(working_register) * $past(mem_rdata))))
    else $error("product bytes misplaced");

  a_mul_working_register_kept: assert property (
    (s_r.phase == MNE_Q1 && s_nxt.op == MNE_OP_MUL) |=> $stable(working_register) [*4])
    else $error("multiply changed working register");

  a_mul_no_write: assert property (
    (s_r.op == MNE_OP_MUL) |-> !mem_we)
    else $error("multiply wrote data memory");

  a_mul_flags_kept: assert property (
    (s_r.phase == MNE_Q3 && s_r.op == MNE_OP_MUL) |=> $stable(flags) ##1 $stable(flags))
    else $error("multiply changed flags");

  a_mul_zero_stored: assert property (
    (s_r.phase == MNE_Q3 && s_r.op == MNE_OP_MUL &&
     (working_register == 8'h00 || mem_rdata == 8'h00)) |=>
      (product_high == 8'h00 && product_low == 8'h00 && !flags.zero == !$past(flags.zero)))
    else $error("zero product mishandled");

  a_neg_value: assert property (
    (s_r.phase == MNE_Q3 && s_r.op == MNE_OP_NEG) |=>
      (mem_wdata == 8'(8'h00 - $past(working_register))))
    else $error("negate value wrong");

  a_neg_both_dest: assert property (
    (s_r.phase == MNE_Q3 && s_r.op == MNE_OP_NEG && !s_r.store_sel) |=>
      (working_register == mem_wdata && mem_we))
    else $error("negate skipped working register");

  a_neg_file_only: assert property (
    (s_r.phase == MNE_Q3 && s_r.op == MNE_OP_NEG && s_r.store_sel) |=>
      ($stable(working_register) && mem_we))
    else $error("negate touched working register");

  a_write_in_q4: assert property (
    mem_we |-> (s_r.phase == MNE_Q4 && s_r.op == MNE_OP_NEG && $past(mem_re, 2)))
    else $error("write outside fourth phase");

  a_decode_mul: assert property (
    (s_r.phase == MNE_Q1 && instr_valid && instr_word[15:8] == 8'h34) |=>
      (s_r.op == MNE_OP_MUL && mem_re && mem_addr == $past(instr_word[7:0])))
    else $error("multiply opcode not decoded");

  a_decode_neg: assert property (
    (s_r.phase == MNE_Q1 && instr_valid && instr_word[15:9] == 7'b0010110) |=>
      (s_r.op == MNE_OP_NEG && mem_re && s_r.store_sel == $past(instr_word[8])))
    else $error("negate opcode not decoded");

  a_idle_quiet: assert property (
    (s_r.op == MNE_OP_NONE) |->
      (!mem_re && !mem_we))
    else $error("memory access without instruction");

  a_read_in_q2: assert property (
    mem_re |->
      (s_r.phase == MNE_Q2 && s_r.op != MNE_OP_NONE))
    else $error("read outside second phase");

  a_flags_only_neg: assert property (
    !(s_r.phase == MNE_Q3 && s_r.op == MNE_OP_NEG) |=>
      $stable(flags))
    else $error("flags changed outside negate");

  a_neg_flags: assert property (
    (s_r.phase == MNE_Q3 && s_r.op == MNE_OP_NEG) |=>
      (flags.zero == (mem_wdata == 8'h00) && flags.carry == ($past(working_register) == 8'h00)
       && flags.half_carry_flag == ($past(working_register[3:0]) == 4'h0)
       && flags.signed_wrap_flag == ($past(working_register) == 8'h80)))
    else $error("negate flags wrong");

  c_mul_run: cover property (s_r.phase == MNE_Q3 && s_r.op == MNE_OP_MUL ##1 product_high != 8'h00);
  c_neg_both: cover property (mem_we && !s_r.store_sel);
  c_neg_file: cover property (mem_we && s_r.store_sel);
  c_neg_wrap: cover property (flags.signed_wrap_flag);
  c_mul_zero: cover property (s_r.op == MNE_OP_MUL && working_register == 8'h00);

endmodule : mne_exec

// ---- tb/mne_exec_bench.sv ----
`timescale 1ns/1ps
module mne_exec_bench;
  import mne_pkg::*;
  typedef struct packed {
    logic [7:0]  w;
    logic [15:0] ins;
    logic [7:0]  rd;
    logic        re;
    logic [15:0] prod;
    logic [7:0]  nw;
    logic        we;
    logic [7:0]  wd;
    logic [3:0]  fl;
  } mne_row_t;
  logic        ref_clk        = 1'b0;
  logic        arst_n         = 1'b0;
  logic [15:0] instr_word     = 16'h0000;
  logic        instr_valid    = 1'b0;
  logic        working_register_load      = 1'b0;
  logic [7:0]  working_register_load_data = 8'h00;
  logic [7:0]  mem_rdata      = 8'h00;
  logic [7:0]  mem_addr, mem_wdata, working_register, product_high, product_low;
  logic        mem_re, mem_we;
  mne_flags_t  flags;
  mne_phase_t  q_phase;
  int          n_mismatch     = 0;
  int          n_checks       = 0;
  mne_row_t    rows [8];

  mne_exec mne_exec_inst (.ref_clk(ref_clk), .arst_n(arst_n), .instr_word(instr_word),
    .instr_valid(instr_valid), .working_register_load(working_register_load), .working_register_load_data(working_register_load_data),
    .mem_addr(mem_addr), .mem_re(mem_re), .mem_rdata(mem_rdata), .mem_we(mem_we),
    .mem_wdata(mem_wdata), .working_register(working_register),
    .product_high(product_high), .product_low(product_low), .flags(flags),
    .q_phase(q_phase));

  initial begin
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %0s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report

  // bounded wait for the decode phase
  task automatic wait_q1();
    for (int i = 0; i < 8; i++) begin
      @(negedge ref_clk);
      if (q_phase === MNE_Q1) return;
    end
    n_mismatch++;
    final_report();
  endtask : wait_q1

  task automatic set_w(input logic [7:0] v);
    wait_q1();
    working_register_load = 1'b1;
    working_register_load_data = v;
    @(negedge ref_clk);
    working_register_load = 1'b0;
  endtask : set_w

  task automatic issue(input logic [15:0] ins);
    wait_q1();
    instr_word = ins;
    instr_valid = 1'b1;
    @(negedge ref_clk);
    instr_valid = 1'b0;
  endtask : issue

  task automatic run_row(input mne_row_t r);
    set_w(r.w);
    issue(r.ins);
    check("mem_re", 16'(mem_re), 16'(r.re));
    if (r.re) check("mem_addr", 16'(mem_addr), 16'(r.ins[7:0]));
    @(negedge ref_clk);
    mem_rdata = r.rd;
    @(negedge ref_clk);
    // read data only valid in the process phase
    mem_rdata = ~r.rd;
    check("product", {product_high, product_low}, r.prod);
    check("working", 16'(working_register), 16'(r.nw));
    check("mem_we", 16'(mem_we), 16'(r.we));
    check("mem_wdata", 16'(mem_wdata), 16'(r.wd));
    check("flags", 16'(flags), 16'(r.fl));
    @(negedge ref_clk);
    check("mem_we_end", 16'(mem_we), 16'h0000);
  endtask : run_row

  initial begin
    rows = '{
      '{8'hc4, 16'h3410, 8'hb5, 1'b1, 16'h8a94, 8'hc4, 1'b0, 8'h00, 4'h0},
      '{8'h3a, 16'h2c20, 8'hab, 1'b1, 16'h8a94, 8'hc6, 1'b1, 8'hc6, 4'h0},
      '{8'h00, 16'h3421, 8'hff, 1'b1, 16'h0000, 8'h00, 1'b0, 8'hc6, 4'h0},
      '{8'h00, 16'h2d22, 8'h5a, 1'b1, 16'h0000, 8'h00, 1'b1, 8'h00, 4'h7},
      '{8'hff, 16'h3423, 8'hff, 1'b1, 16'hfe01, 8'hff, 1'b0, 8'h00, 4'h7},
      '{8'h80, 16'h2c24, 8'h11, 1'b1, 16'hfe01, 8'h80, 1'b1, 8'h80, 4'ha},
      '{8'h10, 16'h2d25, 8'h22, 1'b1, 16'hfe01, 8'h10, 1'b1, 8'hf0, 4'h2},
      '{8'h55, 16'h3526, 8'h33, 1'b0, 16'hfe01, 8'h55, 1'b0, 8'hf0, 4'h2}};
    repeat (5) @(negedge ref_clk);
    arst_n = 1'b1;
    check("reset_phase", 16'(q_phase), 16'(MNE_Q1));
    check("reset_regs", {working_register, product_high}, 16'h0000);
    check("reset_rest", {product_low, 3'h0, mem_we, flags}, 16'h0000);
    $display("test reset done");
    foreach (rows[i]) run_row(rows[i]);
    $display("test table done");
    // instruction offered outside decode phase
    wait_q1();
    @(negedge ref_clk);
    instr_word = 16'h3430;
    instr_valid = 1'b1;
    @(negedge ref_clk);
    instr_valid = 1'b0;
    check("late_re", 16'(mem_re), 16'h0000);
    @(negedge ref_clk);
    check("late_prod", {product_high, product_low}, 16'hfe01);
    // load while idle outside decode phase
    working_register_load = 1'b1;
    working_register_load_data = 8'h5c;
    @(negedge ref_clk);
    working_register_load = 1'b0;
    check("idle_load", 16'(working_register), 16'h005c);
    $display("test late issue done");
    // load attempted while negate in flight
    set_w(8'h3a);
    issue(16'h2c31);
    working_register_load = 1'b1;
    working_register_load_data = 8'haa;
    @(negedge ref_clk);
    working_register_load = 1'b0;
    @(negedge ref_clk);
    check("busy_load", 16'(working_register), 16'h00c6);
    $display("test busy load done");
    issue(16'h3432);
    arst_n = 1'b0;
    #1;
    check("midrst", {product_high, product_low}, 16'h0000);
    check("midrst_w", 16'(working_register), 16'h0000);
    repeat (2) @(negedge ref_clk);
    arst_n = 1'b1;
    run_row(rows[0]);
    $display("test mid reset done");
    final_report();
  end
endmodule : mne_exec_bench
